// ---- design/rx_status_pkg.sv ----
// Constants and types shared by the receive lane and frame status block
package rx_status_pkg;

  // Geometry of the receive path
  localparam int LANE_COUNT    = 20;
  localparam int LANE_IDX_W    = 5;
  localparam int SEG_COUNT     = 4;
  localparam int FCS_W         = 32;
  localparam int BIP_W         = 8;
  localparam int BEAT_BYTES_W  = 7;
  localparam int FRAME_LEN_W   = 16;
  localparam int MAX_LEN_W     = 15;
  localparam int COUNT_W       = 3;

  // Register bus geometry
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CONTROL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MAX_LEN     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LEVELS      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DEMUX       = 8'h18;

  // Control register fields
  localparam int CTRL_TPG_BIT   = 0;

  // Level status register fields
  localparam int LVL_INT_LF_BIT = 0;
  localparam int LVL_RX_LF_BIT  = 1;
  localparam int LVL_HI_BER_BIT = 2;
  localparam int LVL_ALIGN_BIT  = 3;

  // Interrupt status fields
  localparam int IRQ_W          = 7;
  localparam int IRQ_BAD_FCS    = 0;
  localparam int IRQ_STOMPED    = 1;
  localparam int IRQ_TRUNCATED  = 2;
  localparam int IRQ_PARITY     = 3;
  localparam int IRQ_INT_LF     = 4;
  localparam int IRQ_RX_LF      = 5;
  localparam int IRQ_HI_BER     = 6;

  // Reset values
  localparam logic [MAX_LEN_W-1:0] MAX_LEN_RESET = 15'h2580;
  localparam logic [IRQ_W-1:0]     IRQ_EN_RESET  = 7'h00;
  localparam logic                 TPG_RESET     = 1'b0;

  // Timing: error-rate window and its threshold
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BER_WINDOW_NS   = 125000;
  localparam int BER_WINDOW_CYC  = BER_WINDOW_NS / CLK_PERIOD_NS;
  localparam int BER_WIN_W       = 12;
  localparam int BER_THRESHOLD   = 97;
  localparam int BER_ERR_W       = 7;

  // Fault sequence detection
  localparam int LF_COL_LIMIT    = 128;
  localparam int LF_COL_W        = 8;
  localparam int LF_SEQ_NEEDED   = 4;
  localparam int LF_SEQ_W        = 3;

  // Frame length tracking states
  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_BUSY,
    FRAME_DROP
  } frame_state_type;

endpackage : rx_status_pkg

// ---- design/rx_lane_and_frame_status.sv ----
// Receive-path lane map, frame check and fault status logic with register port
//
// Function
// - Per PCS lane, a 5-bit level output naming its physical lane.
// - 20-bit level vector, bit set while lane marker found and lane demultiplexed.
// - 3-bit per-cycle count of bad-FCS frames, stomped ones excluded.
// - FCS is stomped when it equals the complement of the computed FCS.
// - 3-bit per-cycle count of stomped-FCS frames; nonzero means at least one.
// - FCS counts last one cycle per event; may be nonzero back to back.
// - Truncate frame beyond configured 15-bit maximum length; pulse flag one cycle.
// - Internal local fault high while test pattern, misalignment or high BER persist.
// - Received local fault high once enough fault sequences seen, while persisting.
// - Per lane, compare marker BIP8 byte with computed parity; flag mismatch.
// - Per-lane parity error indication lasts one cycle per error, may repeat.
// - High error rate level while measured rate reaches threshold; feeds local fault.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps

module rx_lane_and_frame_status (
  // Clock and reset
  input  wire logic                                      CLK,
  input  wire logic                                      RST,
  // Register port
  input  wire logic [rx_status_pkg::ADDR_W-1:0]          REG_ADDR,
  input  wire logic [rx_status_pkg::DATA_W-1:0]          REG_WDATA,
  input  wire logic                                      REG_WRITE,
  input  wire logic                                      REG_READ,
  output logic      [rx_status_pkg::DATA_W-1:0]          REG_RDATA,
  output logic                                           IRQ,
  // Lane marker events from the lane deskew logic
  input  wire logic                                      MARKER_VALID,
  input  wire logic [rx_status_pkg::LANE_IDX_W-1:0]      MARKER_PCS_LANE,
  input  wire logic [rx_status_pkg::LANE_IDX_W-1:0]      MARKER_PHYS_LANE,
  input  wire logic [rx_status_pkg::BIP_W-1:0]           MARKER_BIP_RX,
  input  wire logic [rx_status_pkg::BIP_W-1:0]           MARKER_BIP_CALC,
  input  wire logic [rx_status_pkg::LANE_COUNT-1:0]      LANE_LOST,
  input  wire logic                                      ALIGN_OK,
  input  wire logic                                      SYNC_HDR_INVALID,
  // Frame ends with received and computed FCS per segment
  input  wire logic [rx_status_pkg::SEG_COUNT-1:0]       FRAME_END,
  input  wire logic [rx_status_pkg::SEG_COUNT-1:0][31:0] FCS_RX,
  input  wire logic [rx_status_pkg::SEG_COUNT-1:0][31:0] FCS_CALC,
  // Frame beats for length tracking
  input  wire logic                                      BEAT_VALID,
  input  wire logic                                      BEAT_SOP,
  input  wire logic                                      BEAT_EOP,
  input  wire logic [rx_status_pkg::BEAT_BYTES_W-1:0]    BEAT_BYTES,
  // Decoded columns for the fault sequence monitor
  input  wire logic                                      COLUMN_VALID,
  input  wire logic                                      COLUMN_LOCAL_FAULT,
  // Status outputs
  output logic [rx_status_pkg::LANE_COUNT-1:0][4:0]      RX_LANE_MAP_INDEX,
  output logic [rx_status_pkg::LANE_COUNT-1:0]           RX_LANE_DEMUX_OK,
  output logic [rx_status_pkg::LANE_COUNT-1:0]           RX_LANE_PARITY_ERROR,
  output logic [rx_status_pkg::COUNT_W-1:0]              RX_FRAME_CHECK_ERROR_COUNT,
  output logic [rx_status_pkg::COUNT_W-1:0]              RX_FRAME_CHECK_POISONED_COUNT,
  output logic                                           RX_TRUNCATED,
  output logic                                           RX_FRAME_DROP,
  output logic                                           RX_INTERNAL_LOCAL_FAULT,
  output logic                                           RX_RECEIVED_LOCAL_FAULT,
  output logic                                           RX_HIGH_ERROR_RATE
);
  import rx_status_pkg::*;

  // All state of the block
  typedef struct packed {
    logic [LANE_COUNT-1:0][LANE_IDX_W-1:0] lane_map;
    logic [LANE_COUNT-1:0]                 demux_ok;
    logic [LANE_COUNT-1:0]                 parity_err;
    logic [COUNT_W-1:0]                    bad_cnt;
    logic [COUNT_W-1:0]                    stomp_cnt;
    logic                                  trunc;
    logic                                  drop;
    frame_state_type                       frame_state;
    logic [FRAME_LEN_W-1:0]                frame_len;
    logic [BER_WIN_W-1:0]                  ber_win;
    logic [BER_ERR_W-1:0]                  ber_err;
    logic                                  hi_ber;
    logic [LF_COL_W-1:0]                   lf_col;
    logic [LF_SEQ_W-1:0]                   lf_seq;
    logic                                  rx_lf;
    logic                                  int_lf;
    logic                                  tpg;
    logic [MAX_LEN_W-1:0]                  max_len;
    logic [IRQ_W-1:0]                      irq_status;
    logic [IRQ_W-1:0]                      irq_en;
    logic                                  irq;
    logic [DATA_W-1:0]                     rdata;
  } state_type;

  state_type q;
  state_type d;

  // Per-segment FCS classification
  logic [SEG_COUNT-1:0] seg_bad;
  logic [SEG_COUNT-1:0] seg_stomp;

  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++) begin : g_seg
      assign seg_stomp[g] = FRAME_END[g] && (FCS_RX[g] == ~FCS_CALC[g]);
      assign seg_bad[g]   = FRAME_END[g] && (FCS_RX[g] != FCS_CALC[g]) && !(FCS_RX[g] == ~FCS_CALC[g]);
    end
  endgenerate

  localparam logic [BER_WIN_W-1:0] BER_WIN_LAST = BER_WIN_W'(BER_WINDOW_CYC - 1);
  localparam logic [BER_ERR_W-1:0] BER_THR      = BER_ERR_W'(BER_THRESHOLD);
  localparam logic [LF_COL_W-1:0]  LF_COL_LAST  = LF_COL_W'(LF_COL_LIMIT - 1);
  localparam logic [LF_SEQ_W-1:0]  LF_SEQ_LAST  = LF_SEQ_W'(LF_SEQ_NEEDED - 1);

  // Next-state logic
  always_comb begin
    logic [FRAME_LEN_W-1:0] len_base;
    logic [FRAME_LEN_W-1:0] len_new;
    logic [IRQ_W-1:0]       events;
    logic                   in_frame;
    len_base = '0;
    len_new  = '0;
    events   = '0;
    in_frame = 1'b0;
    d = q;

    // remember physical lane per PCS lane
    // BIP8 byte compared at each in-range marker
    d.parity_err = '0;
    d.demux_ok   = q.demux_ok & ~LANE_LOST;
    if (MARKER_VALID && (MARKER_PCS_LANE < LANE_IDX_W'(LANE_COUNT))) begin
      d.lane_map[MARKER_PCS_LANE]   = MARKER_PHYS_LANE;
      d.demux_ok[MARKER_PCS_LANE]   = 1'b1;
      d.parity_err[MARKER_PCS_LANE] = (MARKER_BIP_RX != MARKER_BIP_CALC);
    end

    // counts hold for one cycle only
    d.bad_cnt   = COUNT_W'($countones(seg_bad));
    d.stomp_cnt = COUNT_W'($countones(seg_stomp));

    d.trunc  = 1'b0;
    in_frame = BEAT_SOP || (q.frame_state == FRAME_BUSY);
    len_base = BEAT_SOP ? '0 : q.frame_len;
    len_new  = len_base + FRAME_LEN_W'(BEAT_BYTES);
    case (q.frame_state)
      FRAME_IDLE,
      FRAME_BUSY: begin
        if (BEAT_VALID && in_frame) begin
          d.frame_len = len_new;
          if (len_new > FRAME_LEN_W'(q.max_len)) begin
            d.trunc       = 1'b1;
            d.frame_state = BEAT_EOP ? FRAME_IDLE : FRAME_DROP;
          end else begin
            d.frame_state = BEAT_EOP ? FRAME_IDLE : FRAME_BUSY;
          end
        end
      end
      FRAME_DROP: begin
        // Rest of a truncated frame is discarded up to its end
        if (BEAT_VALID && BEAT_EOP) begin
          d.frame_state = FRAME_IDLE;
        end
      end
      default: begin
        d.frame_state = FRAME_IDLE;
      end
    endcase
    // Drop level held in its own flop so the pin is not a state decode
    d.drop = (d.frame_state == FRAME_DROP);

    // count invalid headers over a fixed window
    if (q.ber_win == BER_WIN_LAST) begin
      d.ber_win = '0;
      d.ber_err = '0;
      d.hi_ber  = (q.ber_err >= BER_THR);
    end else begin
      d.ber_win = q.ber_win + 1'b1;
      if (SYNC_HDR_INVALID && (q.ber_err != BER_THR)) begin
        d.ber_err = q.ber_err + 1'b1;
      end
      // Raise at once; clearing waits for a window below the threshold
      if (SYNC_HDR_INVALID && (q.ber_err == BER_THR - 1'b1)) begin
        d.hi_ber = 1'b1;
      end
    end

    // fault sequences must come within a column span
    if (COLUMN_VALID) begin
      if (COLUMN_LOCAL_FAULT) begin
        d.lf_col = '0;
        if (q.lf_seq == LF_SEQ_LAST) begin
          d.rx_lf = 1'b1;
        end else begin
          d.lf_seq = q.lf_seq + 1'b1;
        end
      end else if (q.lf_col == LF_COL_LAST) begin
        // A long gap without fault sequences ends the condition
        d.lf_col = '0;
        d.lf_seq = '0;
        d.rx_lf  = 1'b0;
      end else begin
        d.lf_col = q.lf_col + 1'b1;
      end
    end

    // any cause keeps the internal fault up
    d.int_lf = q.tpg || !ALIGN_OK || q.hi_ber;

    // Interrupt events; set wins over a clear in the same cycle
    events[IRQ_BAD_FCS]   = (d.bad_cnt != '0);
    events[IRQ_STOMPED]   = (d.stomp_cnt != '0);
    events[IRQ_TRUNCATED] = d.trunc;
    events[IRQ_PARITY]    = (d.parity_err != '0);
    events[IRQ_INT_LF]    = d.int_lf && !q.int_lf;
    events[IRQ_RX_LF]     = d.rx_lf && !q.rx_lf;
    events[IRQ_HI_BER]    = d.hi_ber && !q.hi_ber;

    // Register writes
    if (REG_WRITE) begin
      if (REG_ADDR == OFS_CONTROL) begin
        d.tpg = REG_WDATA[CTRL_TPG_BIT];
      end else if (REG_ADDR == OFS_MAX_LEN) begin
        d.max_len = REG_WDATA[MAX_LEN_W-1:0];
      end else if (REG_ADDR == OFS_IRQ_ENABLE) begin
        d.irq_en = REG_WDATA[IRQ_W-1:0];
      end else if (REG_ADDR == OFS_IRQ_CLEAR) begin
        d.irq_status = q.irq_status & ~REG_WDATA[IRQ_W-1:0];
      end
    end
    d.irq_status = d.irq_status | events;
    d.irq        = (d.irq_status & d.irq_en) != '0;

    // Register reads; data stand only in the following cycle
    d.rdata = '0;
    if (REG_READ) begin
      if (REG_ADDR == OFS_CONTROL) begin
        d.rdata[CTRL_TPG_BIT] = q.tpg;
      end else if (REG_ADDR == OFS_MAX_LEN) begin
        d.rdata[MAX_LEN_W-1:0] = q.max_len;
      end else if (REG_ADDR == OFS_IRQ_STATUS) begin
        d.rdata[IRQ_W-1:0] = q.irq_status;
      end else if (REG_ADDR == OFS_IRQ_ENABLE) begin
        d.rdata[IRQ_W-1:0] = q.irq_en;
      end else if (REG_ADDR == OFS_LEVELS) begin
        d.rdata[LVL_INT_LF_BIT] = q.int_lf;
        d.rdata[LVL_RX_LF_BIT]  = q.rx_lf;
        d.rdata[LVL_HI_BER_BIT] = q.hi_ber;
        d.rdata[LVL_ALIGN_BIT]  = ALIGN_OK;
      end else if (REG_ADDR == OFS_DEMUX) begin
        d.rdata[LANE_COUNT-1:0] = q.demux_ok;
      end
    end
  end

  // state register, every field cleared on reset except max_len, loaded with MAX_LEN_RESET
  always_ff @(posedge CLK) begin
    if (RST) begin
      q             <= '0;
      q.frame_state <= FRAME_IDLE;
      q.tpg         <= TPG_RESET;
      q.max_len     <= MAX_LEN_RESET;
      q.irq_en      <= IRQ_EN_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA                     = q.rdata;
  assign IRQ                           = q.irq;
  assign RX_LANE_MAP_INDEX             = q.lane_map;
  assign RX_LANE_DEMUX_OK              = q.demux_ok;
  assign RX_LANE_PARITY_ERROR          = q.parity_err;
  assign RX_FRAME_CHECK_ERROR_COUNT    = q.bad_cnt;
  assign RX_FRAME_CHECK_POISONED_COUNT = q.stomp_cnt;
  assign RX_TRUNCATED                  = q.trunc;
  assign RX_FRAME_DROP                 = q.drop;
  assign RX_INTERNAL_LOCAL_FAULT       = q.int_lf;
  assign RX_RECEIVED_LOCAL_FAULT       = q.rx_lf;
  assign RX_HIGH_ERROR_RATE            = q.hi_ber;

endmodule : rx_lane_and_frame_status

// ---- verification/rx_status_chk.sv ----
// Port assertions for the receive lane and frame status block
`timescale 1ns/100ps

module rx_status_chk (
  // Clock and reset
  input wire logic                                      CLK,
  input wire logic                                      RST,
  // Lane markers
  input wire logic                                      MARKER_VALID,
  input wire logic [rx_status_pkg::LANE_IDX_W-1:0]      MARKER_PCS_LANE,
  input wire logic [rx_status_pkg::LANE_IDX_W-1:0]      MARKER_PHYS_LANE,
  input wire logic [rx_status_pkg::BIP_W-1:0]           MARKER_BIP_RX,
  input wire logic [rx_status_pkg::BIP_W-1:0]           MARKER_BIP_CALC,
  input wire logic                                      ALIGN_OK,
  // Frames
  input wire logic [rx_status_pkg::SEG_COUNT-1:0]       FRAME_END,
  input wire logic [rx_status_pkg::SEG_COUNT-1:0][31:0] FCS_RX,
  input wire logic [rx_status_pkg::SEG_COUNT-1:0][31:0] FCS_CALC,
  input wire logic                                      BEAT_VALID,
  // Status
  input wire logic [rx_status_pkg::LANE_COUNT-1:0][4:0] RX_LANE_MAP_INDEX,
  input wire logic [rx_status_pkg::LANE_COUNT-1:0]      RX_LANE_DEMUX_OK,
  input wire logic [rx_status_pkg::LANE_COUNT-1:0]      RX_LANE_PARITY_ERROR,
  input wire logic [rx_status_pkg::COUNT_W-1:0]         RX_FRAME_CHECK_ERROR_COUNT,
  input wire logic [rx_status_pkg::COUNT_W-1:0]         RX_FRAME_CHECK_POISONED_COUNT,
  input wire logic                                      RX_TRUNCATED,
  input wire logic                                      RX_INTERNAL_LOCAL_FAULT,
  input wire logic                                      RX_RECEIVED_LOCAL_FAULT
);
  import rx_status_pkg::*;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Lane map and demux follow each accepted marker
  AST_MAP_FOLLOWS: assert property (MARKER_VALID && MARKER_PCS_LANE < 5'd20
    |=> RX_LANE_MAP_INDEX[$past(MARKER_PCS_LANE)] == $past(MARKER_PHYS_LANE)) else $error("map not updated");
  AST_MAP_HOLDS: assert property (!MARKER_VALID |=> $stable(RX_LANE_MAP_INDEX)) else $error("map moved");
  AST_DEMUX_SET: assert property (MARKER_VALID && MARKER_PCS_LANE < 5'd20
    |=> RX_LANE_DEMUX_OK[$past(MARKER_PCS_LANE)]) else $error("demux not set");
  // Parity flags only on a mismatching marker
  AST_PARITY_SET: assert property (MARKER_VALID && MARKER_PCS_LANE < 5'd20 && MARKER_BIP_RX != MARKER_BIP_CALC
    |=> RX_LANE_PARITY_ERROR[$past(MARKER_PCS_LANE)]) else $error("parity not flagged");
  AST_PARITY_IDLE: assert property (!MARKER_VALID |=> RX_LANE_PARITY_ERROR == '0) else $error("parity held");
  // Frame check counts are pulses tied to frame ends
  AST_COUNTS_IDLE: assert property (FRAME_END == '0
    |=> RX_FRAME_CHECK_ERROR_COUNT == '0 && RX_FRAME_CHECK_POISONED_COUNT == '0) else $error("count held");
  AST_POISON_ALL: assert property (FRAME_END == 4'hf && FCS_RX == ~FCS_CALC
    |=> RX_FRAME_CHECK_POISONED_COUNT == 3'h4 && RX_FRAME_CHECK_ERROR_COUNT == '0) else $error("poison count");
  AST_TRUNC_IDLE: assert property (!BEAT_VALID |=> !RX_TRUNCATED) else $error("truncation without beat");
  AST_ALIGN_FAULT: assert property (!ALIGN_OK |=> RX_INTERNAL_LOCAL_FAULT) else $error("no fault");

  // Main scenarios reached
  CVR_PARITY: cover property (MARKER_VALID && MARKER_BIP_RX != MARKER_BIP_CALC);
  CVR_TRUNC: cover property (RX_TRUNCATED);
  CVR_RX_FAULT: cover property (RX_RECEIVED_LOCAL_FAULT);
endmodule : rx_status_chk

bind rx_lane_and_frame_status rx_status_chk i_chk (.*);

// ---- verification/rx_status_monitor.sv ----
// Partner model: user logic updating lane map entries only while lanes are synced
`timescale 1ns/100ps

module rx_status_monitor (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Sync bus and lane map seen
  input  wire logic [19:0]      lane_sync_ok,
  input  wire logic [19:0][4:0] lane_map,
  // Entries the user trusts
  output logic      [19:0][4:0] trusted_map
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < 20; i++) begin
      if (rst) trusted_map[i] <= 5'h00;
      else if (lane_sync_ok[i]) trusted_map[i] <= lane_map[i];
    end
  end
endmodule : rx_status_monitor

// ---- verification/rx_lane_and_frame_status_tb.sv ----
// Self-checking testbench for the receive lane and frame status block
`timescale 1ns/100ps

module rx_lane_and_frame_status_tb import rx_status_pkg::*;;
  localparam logic [31:0] GOOD = 32'h1234abcd;
  logic CLK, RST, REG_WRITE, REG_READ, MARKER_VALID, ALIGN_OK, SYNC_HDR_INVALID, IRQ;
  logic BEAT_VALID, BEAT_SOP, BEAT_EOP, COLUMN_VALID, COLUMN_LOCAL_FAULT;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
  logic [LANE_IDX_W-1:0] MARKER_PCS_LANE, MARKER_PHYS_LANE;
  logic [BIP_W-1:0] MARKER_BIP_RX, MARKER_BIP_CALC;
  logic [LANE_COUNT-1:0] LANE_LOST, RX_LANE_DEMUX_OK, RX_LANE_PARITY_ERROR, lane_sync_ok;
  logic [SEG_COUNT-1:0] FRAME_END;
  logic [SEG_COUNT-1:0][31:0] FCS_RX, FCS_CALC;
  logic [BEAT_BYTES_W-1:0] BEAT_BYTES;
  logic [LANE_COUNT-1:0][4:0] RX_LANE_MAP_INDEX, trusted_map;
  logic [COUNT_W-1:0] RX_FRAME_CHECK_ERROR_COUNT, RX_FRAME_CHECK_POISONED_COUNT;
  logic RX_TRUNCATED, RX_FRAME_DROP, RX_INTERNAL_LOCAL_FAULT, RX_RECEIVED_LOCAL_FAULT, RX_HIGH_ERROR_RATE;
  int failures;
  int total_checks;

  rx_lane_and_frame_status i_dut (.*);
  rx_status_monitor i_mon (.clk(CLK), .rst(RST), .lane_sync_ok(lane_sync_ok), .lane_map(RX_LANE_MAP_INDEX),
    .trusted_map(trusted_map));

  // 20 MHz clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Register cycles: strobes last one cycle
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge CLK);
    REG_WRITE <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(logic [7:0] a, logic [31:0] e, string n);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_READ <= 1'b1;
    @(posedge CLK);
    REG_READ <= 1'b0;
    #1;
    chk(n, e, REG_RDATA);
  endtask : reg_rd

  // One frame beat; checks the truncation flag of the beat before
  task automatic beat(logic s, logic e, logic [6:0] n, logic t);
    @(posedge CLK);
    BEAT_VALID <= 1'b1;
    BEAT_SOP <= s;
    BEAT_EOP <= e;
    BEAT_BYTES <= n;
    #1;
    chk("truncated", 32'(t), 32'(RX_TRUNCATED));
  endtask : beat

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    close_out();
  end

  initial begin
    {REG_WRITE, REG_READ, MARKER_VALID, SYNC_HDR_INVALID, BEAT_VALID, BEAT_SOP, BEAT_EOP} = '0;
    {COLUMN_VALID, COLUMN_LOCAL_FAULT, REG_ADDR, REG_WDATA, MARKER_PCS_LANE, MARKER_PHYS_LANE} = '0;
    {MARKER_BIP_RX, MARKER_BIP_CALC, LANE_LOST, FRAME_END, FCS_RX, FCS_CALC, BEAT_BYTES, lane_sync_ok} = '0;
    RST = 1'b1;
    ALIGN_OK = 1'b1;
    failures = 0;
    total_checks = 0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    // Reset values, unmapped address reads zero
    reg_rd(OFS_MAX_LEN, 32'h2580, "max len");
    reg_rd(OFS_CONTROL, 32'h0, "control");
    reg_rd(8'h1c, 32'h0, "unmapped");
    // Markers back to back on every lane, then an out-of-range lane
    for (int i = 0; i < 22; i++) begin
      @(posedge CLK);
      MARKER_VALID <= (i < 21);
      MARKER_PCS_LANE <= 5'(i);
      MARKER_PHYS_LANE <= 5'(19 - i);
      MARKER_BIP_RX <= 8'(i);
      MARKER_BIP_CALC <= 8'(i) ^ 8'(i % 2 == 0);
      #1;
      if (i > 0 && i < 21) chk("lane map", 32'(20 - i), 32'(RX_LANE_MAP_INDEX[i-1]));
      if (i > 0) chk("parity", (i % 2 == 1 && i < 21) ? 32'h1 << (i - 1) : 32'h0, 32'(RX_LANE_PARITY_ERROR));
    end
    chk("demux", 32'hfffff, 32'(RX_LANE_DEMUX_OK));
    @(posedge CLK);
    LANE_LOST <= 20'h00020;
    @(posedge CLK);
    LANE_LOST <= '0;
    lane_sync_ok <= 20'h00080;
    reg_rd(OFS_DEMUX, 32'hfffdf, "demux reg");
    chk("trusted 7", 32'd12, 32'(trusted_map[7]));
    chk("trusted 8", 32'd0, 32'(trusted_map[8]));
    // Four frame ends: bad, stomped, good, bad; then four stomped
    @(posedge CLK);
    FRAME_END <= 4'hf;
    FCS_CALC <= {4{GOOD}};
    FCS_RX <= {32'h0, GOOD, ~GOOD, 32'h0};
    @(posedge CLK);
    FCS_RX <= {4{~GOOD}};
    #1;
    chk("bad fcs", 32'd2, 32'(RX_FRAME_CHECK_ERROR_COUNT));
    chk("stomped", 32'd1, 32'(RX_FRAME_CHECK_POISONED_COUNT));
    @(posedge CLK);
    FRAME_END <= '0;
    #1;
    chk("bad fcs", 32'd0, 32'(RX_FRAME_CHECK_ERROR_COUNT));
    chk("stomped", 32'd4, 32'(RX_FRAME_CHECK_POISONED_COUNT));
    @(posedge CLK);
    #1;
    chk("stomped", 32'd0, 32'(RX_FRAME_CHECK_POISONED_COUNT));
    // Oversize frame is cut; a frame of exactly the maximum is not
    reg_wr(OFS_MAX_LEN, 32'd100);
    beat(1'b1, 1'b0, 7'd64, 1'b0);
    beat(1'b0, 1'b0, 7'd64, 1'b0);
    beat(1'b0, 1'b0, 7'd8, 1'b1);
    chk("drop", 32'd1, 32'(RX_FRAME_DROP));
    beat(1'b0, 1'b1, 7'd8, 1'b0);
    beat(1'b1, 1'b0, 7'd64, 1'b0);
    beat(1'b0, 1'b1, 7'd36, 1'b0);
    beat(1'b0, 1'b0, 7'd0, 1'b0);
    @(posedge CLK);
    BEAT_VALID <= 1'b0;
    #1;
    chk("truncated", 32'd0, 32'(RX_TRUNCATED));
    chk("drop", 32'd0, 32'(RX_FRAME_DROP));
    // Sticky status, enable, clear and masking
    reg_rd(OFS_IRQ_STATUS, 32'h0f, "status");
    reg_wr(OFS_IRQ_ENABLE, 32'h02);
    reg_rd(OFS_IRQ_ENABLE, 32'h02, "enable");
    chk("irq", 32'd1, 32'(IRQ));
    reg_wr(OFS_IRQ_CLEAR, 32'h02);
    reg_wr(OFS_IRQ_STATUS, 32'h0);
    reg_rd(OFS_IRQ_STATUS, 32'h0d, "status");
    chk("irq", 32'd0, 32'(IRQ));
    reg_wr(OFS_IRQ_ENABLE, 32'h01);
    reg_rd(OFS_IRQ_CLEAR, 32'h0, "clear reg");
    chk("irq", 32'd1, 32'(IRQ));
    // Internal fault from misalignment, then from the test pattern
    @(posedge CLK);
    ALIGN_OK <= 1'b0;
    @(posedge CLK);
    #1;
    chk("int fault", 32'd1, 32'(RX_INTERNAL_LOCAL_FAULT));
    reg_rd(OFS_LEVELS, 32'h1, "levels");
    @(posedge CLK);
    ALIGN_OK <= 1'b1;
    reg_wr(OFS_CONTROL, 32'h1);
    @(posedge CLK);
    #1;
    chk("int fault", 32'd1, 32'(RX_INTERNAL_LOCAL_FAULT));
    reg_wr(OFS_CONTROL, 32'h0);
    @(posedge CLK);
    #1;
    chk("int fault", 32'd0, 32'(RX_INTERNAL_LOCAL_FAULT));
    // Four fault columns raise, 128 clean columns clear
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      COLUMN_VALID <= 1'b1;
      COLUMN_LOCAL_FAULT <= 1'b1;
      #1;
      if (i == 3) chk("rx fault", 32'd0, 32'(RX_RECEIVED_LOCAL_FAULT));
    end
    @(posedge CLK);
    COLUMN_LOCAL_FAULT <= 1'b0;
    #1;
    chk("rx fault", 32'd1, 32'(RX_RECEIVED_LOCAL_FAULT));
    repeat (127) @(posedge CLK);
    #1;
    chk("rx fault", 32'd1, 32'(RX_RECEIVED_LOCAL_FAULT));
    @(posedge CLK);
    COLUMN_VALID <= 1'b0;
    #1;
    chk("rx fault", 32'd0, 32'(RX_RECEIVED_LOCAL_FAULT));
    // Twice the threshold of bad headers: at least one window reaches it
    for (int i = 0; i < 194; i++) begin
      @(posedge CLK);
      SYNC_HDR_INVALID <= 1'b1;
    end
    @(posedge CLK);
    SYNC_HDR_INVALID <= 1'b0;
    #1;
    chk("hi rate", 32'd1, 32'(RX_HIGH_ERROR_RATE));
    // Internal fault trails the rate flag by a cycle; rate may rise on the last header
    @(posedge CLK);
    #1;
    chk("int fault", 32'd1, 32'(RX_INTERNAL_LOCAL_FAULT));
    for (int i = 0; i < 5100; i++) begin
      @(posedge CLK);
      #1;
      if (RX_HIGH_ERROR_RATE !== 1'b1) break;
    end
    chk("hi rate", 32'd0, 32'(RX_HIGH_ERROR_RATE));
    // Fault rises are sticky too; stomped bit stays cleared
    reg_rd(OFS_IRQ_STATUS, 32'h7d, "status");
    // Counts stay zero while held in reset
    @(posedge CLK);
    RST <= 1'b1;
    FRAME_END <= 4'hf;
    repeat (2) @(posedge CLK);
    #1;
    chk("stomped", 32'd0, 32'(RX_FRAME_CHECK_POISONED_COUNT));
    @(posedge CLK);
    FRAME_END <= '0;
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk("lane map", 32'd0, 32'(RX_LANE_MAP_INDEX[7]));
    close_out();
  end
endmodule : rx_lane_and_frame_status_tb
